// *** apf_pkg.sv ***
package apf_pkg;
  localparam int APF_WIDTH = 9;
  localparam int APF_DEPTH = 1024;
  localparam int APF_CLK_MHZ = 40;
  // strobe pulse and recovery times in ns, turned into cycles below
  localparam int APF_T_STROBE_NS = 75;
  localparam int APF_T_RECOVER_NS = 50;
  localparam int APF_T_RESET_NS = 100;
  localparam int APF_T_REPLAY_NS = 75;
  localparam int APF_CYC_STROBE = (APF_T_STROBE_NS * APF_CLK_MHZ + 999) / 1000;
  localparam int APF_CYC_RECOVER = (APF_T_RECOVER_NS * APF_CLK_MHZ + 999) / 1000;
  localparam int APF_CYC_RESET = (APF_T_RESET_NS * APF_CLK_MHZ + 999) / 1000;
  localparam int APF_CYC_REPLAY = (APF_T_REPLAY_NS * APF_CLK_MHZ + 999) / 1000;
  localparam int APF_CNT_W = 4;
  localparam logic [APF_WIDTH-1:0] APF_DATA_RST = 9'h000;
  localparam logic [1:0] APF_BUF_RST = 2'h0;
  typedef enum logic [2:0] {
    APF_RESET = 3'h0,
    APF_IDLE = 3'h1,
    APF_WR_LOW = 3'h3,
    APF_RD_LOW = 3'h2,
    APF_RECOVER = 3'h6,
    APF_REPLAY = 3'h7,
    APF_INIT_HOLD = 3'h5
  } apf_state_t;
endpackage

// *** apf_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - controller applies clear_n after power-up before any write.
// - strobes held high around clear_n release and for recovery after it.
// - write data held stable across the write strobe rising edge.
// - controller keeps both strobes high during a replay pulse.
// - replay only used while writes since clear fit the depth; the controller does not count writes and replays on any replay_req.
module apf_ctrl #(
  parameter int WIDTH = apf_pkg::APF_WIDTH,
  parameter int DEPTH = apf_pkg::APF_DEPTH
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [WIDTH-1:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready,
  input wire logic replay_req,
  output logic replay_done,
  output logic fifo_full,
  output logic fifo_empty,
  output logic fifo_half,
  output logic ready,
  output logic clear_n,
  output logic write_n,
  output logic read_n,
  output logic first_device_or_replay_n,
  output logic [WIDTH-1:0] write_data,
  input wire logic [WIDTH-1:0] read_data,
  input wire logic empty_indicator_n,
  input wire logic full_indicator_n,
  input wire logic chain_out_or_half_level_n
);
  import apf_pkg::*;
  // ----------------------------------------
  // pin synchronisers and two-entry read buffer
  // ----------------------------------------
  logic [2:0] fl_s1_reg, fl_s2_reg, fl_s1_next, fl_s2_next;
  logic [WIDTH-1:0] rd_s1_reg, rd_s2_reg, rd_s1_next, rd_s2_next;
  wire logic empty_s = ~fl_s2_reg[2];
  wire logic full_s = ~fl_s2_reg[1];
  wire logic half_s = ~fl_s2_reg[0];
  logic [WIDTH-1:0] buf_reg [2];
  logic [WIDTH-1:0] buf_next [2];
  logic [1:0] cnt_reg, cnt_next;
  logic push, pop;
  always_comb
  begin
    fl_s1_next = {empty_indicator_n, full_indicator_n, chain_out_or_half_level_n};
    fl_s2_next = fl_s1_reg;
    rd_s1_next = read_data;
    rd_s2_next = rd_s1_reg;
    buf_next = buf_reg;
    cnt_next = cnt_reg;
    if (pop)
      buf_next[0] = buf_reg[1];
    if (push)
      buf_next[(pop ? cnt_reg - 2'h1 : cnt_reg) == 2'h0 ? 0 : 1] = rd_s2_reg;
    cnt_next = 2'(cnt_reg + {1'b0, push} - {1'b0, pop});
  end
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      fl_s1_reg <= 3'h7;
      fl_s2_reg <= 3'h7;
      rd_s1_reg <= APF_DATA_RST;
      rd_s2_reg <= APF_DATA_RST;
      buf_reg[0] <= APF_DATA_RST;
      buf_reg[1] <= APF_DATA_RST;
      cnt_reg <= APF_BUF_RST;
    end
    else
    begin
      fl_s1_reg <= fl_s1_next;
      fl_s2_reg <= fl_s2_next;
      rd_s1_reg <= rd_s1_next;
      rd_s2_reg <= rd_s2_next;
      buf_reg <= buf_next;
      cnt_reg <= cnt_next;
    end
  end
  // ----------------------------------------
  // strobe sequencer
  // ----------------------------------------
  apf_state_t st_reg, st_next;
  logic [APF_CNT_W-1:0] tm_reg, tm_next;
  logic cl_reg, cl_next, wn_reg, wn_next, rn_reg, rn_next, rp_reg, rp_next;
  logic wr_rdy_reg, wr_rdy_next, done_reg, done_next, rdy_reg, rdy_next;
  logic [WIDTH-1:0] wd_reg, wd_next;
  logic need_settle_reg, need_settle_next;
  always_comb
  begin
    st_next = st_reg;
    tm_next = (tm_reg != '0) ? tm_reg - 1'b1 : tm_reg;
    cl_next = cl_reg;
    wn_next = wn_reg;
    rn_next = rn_reg;
    rp_next = rp_reg;
    wd_next = wd_reg;
    wr_rdy_next = 1'b0;
    done_next = 1'b0;
    rdy_next = rdy_reg;
    need_settle_next = need_settle_reg;
    push = 1'b0;
    case (st_reg)
      APF_RESET:
      begin
        // strobes stay high through the clear pulse and its recovery
        cl_next = 1'b0;
        wn_next = 1'b1;
        rn_next = 1'b1;
        if (tm_reg == '0)
        begin
          cl_next = 1'b1;
          tm_next = APF_CNT_W'(APF_CYC_RECOVER + 3);
          st_next = APF_INIT_HOLD;
        end
      end
      APF_INIT_HOLD:
        // flags read only after recovery plus synchroniser delay
        if (tm_reg == '0)
        begin
          rdy_next = 1'b1;
          st_next = APF_IDLE;
        end
      APF_IDLE:
        // stale flags after a strobe: wait for the synchroniser to catch up
        if (need_settle_reg)
        begin
          tm_next = 4'h3;
          need_settle_next = 1'b0;
          st_next = APF_RECOVER;
        end
        else if (replay_req)
        begin
          // replay with both strobes idle high
          rp_next = 1'b0;
          tm_next = APF_CNT_W'(APF_CYC_REPLAY);
          st_next = APF_REPLAY;
        end
        else if (!empty_s && cnt_reg != 2'h2)
        begin
          // no read while empty is flagged
          rn_next = 1'b0;
          tm_next = APF_CNT_W'(APF_CYC_STROBE);
          st_next = APF_RD_LOW;
        end
        else if (wr_valid && !full_s)
        begin
          // only write while full is clear
          wn_next = 1'b0;
          wd_next = wr_data;
          wr_rdy_next = 1'b1;
          tm_next = APF_CNT_W'(APF_CYC_STROBE);
          st_next = APF_WR_LOW;
        end
      APF_WR_LOW:
        // data stays on the pins past the rising edge
        if (tm_reg == '0)
        begin
          wn_next = 1'b1;
          tm_next = APF_CNT_W'(APF_CYC_RECOVER);
          need_settle_next = 1'b1;
          st_next = APF_RECOVER;
        end
      APF_RD_LOW:
        // sample output while the read strobe is still low
        if (tm_reg == '0)
        begin
          push = 1'b1;
          rn_next = 1'b1;
          tm_next = APF_CNT_W'(APF_CYC_RECOVER);
          need_settle_next = 1'b1;
          st_next = APF_RECOVER;
        end
      APF_REPLAY:
        if (tm_reg == '0)
        begin
          rp_next = 1'b1;
          done_next = 1'b1;
          tm_next = APF_CNT_W'(APF_CYC_RECOVER);
          need_settle_next = 1'b1;
          st_next = APF_RECOVER;
        end
      APF_RECOVER:
        if (tm_reg == '0)
          st_next = APF_IDLE;
      default:
        st_next = APF_RESET;
    endcase
  end
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      st_reg <= APF_RESET;
      tm_reg <= APF_CNT_W'(APF_CYC_RESET);
      cl_reg <= 1'b0;
      wn_reg <= 1'b1;
      rn_reg <= 1'b1;
      rp_reg <= 1'b1;
      wd_reg <= APF_DATA_RST;
      wr_rdy_reg <= 1'b0;
      done_reg <= 1'b0;
      rdy_reg <= 1'b0;
      need_settle_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      tm_reg <= tm_next;
      cl_reg <= cl_next;
      wn_reg <= wn_next;
      rn_reg <= rn_next;
      rp_reg <= rp_next;
      wd_reg <= wd_next;
      wr_rdy_reg <= wr_rdy_next;
      done_reg <= done_next;
      rdy_reg <= rdy_next;
      need_settle_reg <= need_settle_next;
    end
  end
  assign pop = (cnt_reg != 2'h0) && rd_ready;
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // single-device mode assumed: chain_in_n tied low at board, so pin 3 is half flag
  assign clear_n = cl_reg;
  assign write_n = wn_reg;
  assign read_n = rn_reg;
  assign first_device_or_replay_n = rp_reg;
  assign write_data = wd_reg;
  assign wr_ready = wr_rdy_reg;
  assign rd_data = buf_reg[0];
  assign rd_valid = (cnt_reg != 2'h0);
  assign replay_done = done_reg;
  assign fifo_full = full_s;
  assign fifo_empty = empty_s;
  assign fifo_half = half_s;
  assign ready = rdy_reg;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_strobes_high_in_clear;
    @(posedge ref_clk) disable iff (reset) !cl_reg |-> (wn_reg && rn_reg);
  endproperty
  a_strobes_high_in_clear: assert property (p_strobes_high_in_clear) else $error("strobe low during clear");
  property p_strobes_high_in_replay;
    @(posedge ref_clk) disable iff (reset) !rp_reg |-> (wn_reg && rn_reg && cl_reg);
  endproperty
  a_strobes_high_in_replay: assert property (p_strobes_high_in_replay) else $error("strobe low during replay");
  property p_no_write_when_full;
    @(posedge ref_clk) disable iff (reset) ($fell(wn_reg)) |-> $past(!full_s);
  endproperty
  a_no_write_when_full: assert property (p_no_write_when_full) else $error("write started while full");
  property p_no_read_when_empty;
    @(posedge ref_clk) disable iff (reset) ($fell(rn_reg)) |-> $past(!empty_s);
  endproperty
  a_no_read_when_empty: assert property (p_no_read_when_empty) else $error("read started while empty");
  property p_data_held;
    @(posedge ref_clk) disable iff (reset) (!wn_reg ##1 wn_reg) |-> $stable(wd_reg);
  endproperty
  a_data_held: assert property (p_data_held) else $error("write data moved at strobe rise");
  property p_clear_first;
    @(posedge ref_clk) disable iff (reset) !rdy_reg |-> (wn_reg && rn_reg);
  endproperty
  a_clear_first: assert property (p_clear_first) else $error("access before clear finished");
  property p_strobe_exclusive;
    @(posedge ref_clk) disable iff (reset) !(!wn_reg && !rn_reg);
  endproperty
  a_strobe_exclusive: assert property (p_strobe_exclusive) else $error("both strobes low");
  property p_replay_done;
    @(posedge ref_clk) disable iff (reset) $fell(rp_reg) |-> ##[1:8] replay_done;
  endproperty
  a_replay_done: assert property (p_replay_done) else $error("replay did not finish");
endmodule
`default_nettype wire

// *** apf_dev_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// device model, single-device mode or depth mode selected by chain_in_n
// ----------------------------------------
module apf_dev_model
  import apf_pkg::*;
#(
  parameter int WIDTH = APF_WIDTH,
  parameter int DEPTH = 8
) (
  input wire logic clear_n,
  input wire logic write_n,
  input wire logic read_n,
  input wire logic first_device_or_replay_n,
  input wire logic chain_in_n,
  input wire logic [WIDTH-1:0] write_data,
  output logic [WIDTH-1:0] read_data,
  output logic empty_indicator_n,
  output logic full_indicator_n,
  output logic chain_out_or_half_level_n
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] last = '0;
  int wp = 0;
  int rp = 0;
  int cnt = 0;
  bit wr_go = 0;
  bit rd_go = 0;
  bit rd_on = 0;
  bit chain_pulse = 0;
  assign empty_indicator_n = (cnt != 0);
  assign full_indicator_n = (cnt != DEPTH);
  // depth mode: shared pin goes low once the last location is written and stays low until the next write
  assign chain_out_or_half_level_n = chain_in_n ? !chain_pulse : !(cnt > DEPTH / 2);
  // released bus shows the inverse of the last word, so a stale sample is caught
  assign read_data = rd_on ? last : ~last;
  always @(negedge clear_n)
  begin
    wp = 0;
    rp = 0;
    cnt = 0;
    rd_on = 0;
  end
  always @(negedge write_n)
    wr_go = clear_n && full_indicator_n;
  always @(posedge write_n)
  begin
    if (wr_go && clear_n)
    begin
      mem[wp] = write_data;
      wp = (wp + 1) % DEPTH;
      cnt++;
      chain_pulse = chain_in_n && (wp == 0);
    end
    wr_go = 0;
  end
  always @(negedge read_n)
  begin
    rd_go = clear_n && empty_indicator_n;
    if (rd_go)
    begin
      last = mem[rp];
      rd_on = 1;
    end
  end
  always @(posedge read_n)
  begin
    if (rd_go && clear_n)
    begin
      rp = (rp + 1) % DEPTH;
      cnt--;
    end
    rd_go = 0;
    rd_on = 0;
  end
  // count from write pointer holds only while writes since clear fit the depth
  always @(negedge first_device_or_replay_n)
  begin
    // in depth mode the pin only marks the first device, never replays
    if (clear_n && !chain_in_n && write_n && read_n)
    begin
      rp = 0;
      cnt = wp;
    end
  end
endmodule
`default_nettype wire

// *** tb_apf_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_fail++; \
  $display("mismatch %s exp %h got %h", nm, ex, got); end end
module tb_apf_ctrl;
  import apf_pkg::*;
  localparam int DEPTH = 8;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [APF_WIDTH-1:0] wr_data = 9'h000;
  logic wr_valid = 1'b0;
  logic rd_ready = 1'b0;
  logic replay_req = 1'b0;
  logic wr_ready, rd_valid, replay_done, fifo_full, fifo_empty, fifo_half, ready;
  logic clear_n, write_n, read_n, first_device_or_replay_n;
  logic [APF_WIDTH-1:0] rd_data, write_data, read_data;
  logic empty_indicator_n, full_indicator_n, chain_out_or_half_level_n;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;
  int hits;
  always #12.5 ref_clk = ~ref_clk;
  // small depth so full and wrap are reached in a short run
  apf_ctrl #(.DEPTH(DEPTH)) i_apf_ctrl (.ref_clk, .reset, .wr_data, .wr_valid, .wr_ready, .rd_data,
    .rd_valid, .rd_ready, .replay_req, .replay_done, .fifo_full, .fifo_empty, .fifo_half, .ready,
    .clear_n, .write_n, .read_n, .first_device_or_replay_n, .write_data, .read_data,
    .empty_indicator_n, .full_indicator_n, .chain_out_or_half_level_n);
  apf_dev_model #(.DEPTH(DEPTH)) i_apf_dev_model (.clear_n, .write_n, .read_n, .first_device_or_replay_n,
    .chain_in_n(1'b0), .write_data, .read_data, .empty_indicator_n, .full_indicator_n,
    .chain_out_or_half_level_n);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic conclude();
    $display("counts: %0d checks, %0d mismatches", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [APF_WIDTH-1:0] word(input int k);
    return APF_WIDTH'(k * 37 + 9'h1A5);
  endfunction
  task automatic do_reset();
    reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    for (int i = 0; i < 40 && ready !== 1'b1; i++) @(negedge ref_clk);
    `CHK("ready", 1'b1, ready)
  endtask
  task automatic push(input logic [APF_WIDTH-1:0] w);
    @(negedge ref_clk);
    wr_data = w;
    wr_valid = 1'b1;
    for (int i = 0; i < 60 && wr_ready !== 1'b1; i++) @(negedge ref_clk);
    `CHK("wr_ready", 1'b1, wr_ready)
    wr_valid = 1'b0;
  endtask
  task automatic pop(input logic [APF_WIDTH-1:0] w);
    for (int i = 0; i < 60 && rd_valid !== 1'b1; i++) @(negedge ref_clk);
    `CHK("rd_valid", 1'b1, rd_valid)
    `CHK("rd_data", w, rd_data)
    rd_ready = 1'b1;
    @(negedge ref_clk);
    rd_ready = 1'b0;
  endtask
  // flags cross two flops, so let them settle before looking
  task automatic flags(input logic e, input logic f, input logic h);
    repeat (12) @(negedge ref_clk);
    `CHK("fifo_empty", e, fifo_empty)
    `CHK("fifo_full", f, fifo_full)
    `CHK("fifo_half", h, fifo_half)
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      conclude();
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    do_reset();
    flags(1'b1, 1'b0, 1'b0);
    $display("test reset done");
    for (int k = 0; k < 3; k++) push(word(k));
    for (int k = 0; k < 3; k++) pop(word(k));
    flags(1'b1, 1'b0, 1'b0);
    $display("test order done");
    for (int k = 0; k < DEPTH + 2; k++) push(word(10 + k));
    flags(1'b0, 1'b1, 1'b1);
    @(negedge ref_clk);
    wr_data = word(20);
    wr_valid = 1'b1;
    hits = 0;
    repeat (40) @(negedge ref_clk) hits += int'(wr_ready === 1'b1);
    `CHK("blocked", 0, hits)
    pop(word(10));
    push(word(20));
    for (int k = 1; k < DEPTH + 2; k++) pop(word(10 + k));
    pop(word(20));
    flags(1'b1, 1'b0, 1'b0);
    $display("test full done");
    push(word(40));
    push(word(41));
    do_reset();
    flags(1'b1, 1'b0, 1'b0);
    `CHK("rd_valid", 1'b0, rd_valid)
    $display("test clear done");
    for (int k = 0; k < 5; k++) push(word(30 + k));
    for (int k = 0; k < 5; k++) pop(word(30 + k));
    replay_req = 1'b1;
    for (int i = 0; i < 40 && replay_done !== 1'b1; i++) @(negedge ref_clk);
    replay_req = 1'b0;
    `CHK("replay_done", 1'b1, replay_done)
    `CHK("fifo_half", 1'b1, fifo_half)
    for (int k = 0; k < 5; k++) pop(word(30 + k));
    flags(1'b1, 1'b0, 1'b0);
    $display("test replay done");
    conclude();
  end
endmodule
`default_nettype wire
